// file: src/ttx_port_regs.vh
`ifndef TTX_PORT_REGS_VH
`define TTX_PORT_REGS_VH
// ==========================================================
// Register select decode
`define TTX_SEL_DATA 1'b0
`define TTX_SEL_CTRL 1'b1
// ==========================================================
// Control A fields
`define TTX_CTLA_TONE_OUT 0
`define TTX_CTLA_PROGRESS 1
`define TTX_CTLA_IRQ_EN 2
`define TTX_CTLA_BANK_SEL 3
// ==========================================================
// Control B fields
`define TTX_CTLB_BURST_N 0
`define TTX_CTLB_TEST 1
`define TTX_CTLB_SINGLE 2
`define TTX_CTLB_COLUMN 3
// ==========================================================
// Status fields
`define TTX_ST_IRQ 0
`define TTX_ST_TX_EMPTY 1
`define TTX_ST_RX_FULL 2
`define TTX_ST_DSTEER 3
// ==========================================================
// Reset values (host must still run its init sequence)
`define TTX_CTLA_RESET 4'h0
`define TTX_CTLB_RESET 4'h1
`define TTX_STATUS_RESET 4'h8
// ==========================================================
// Burst timing: clock 40 MHz, burst/pause 51 ms, doubled in progress mode
`define TTX_CLK_HZ 40000000
`define TTX_BURST_MS 51
`define TTX_BURST_CYCLES ((`TTX_CLK_HZ / 1000) * `TTX_BURST_MS)
`endif

// file: src/ttx_digit_reg.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Four-bit digit holding register, read data registered
module ttx_digit_reg (
    input wire ref_clk,
    input wire rst_n,
    input wire load,
    input wire [3:0] load_data,
    output reg [3:0] hold_data
);
    // Keeps the last loaded digit until the next load
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            hold_data <= 4'h0;
        end else if (load) begin
            hold_data <= load_data;
        end
    end
endmodule
`default_nettype wire

// file: src/ttx_host_port.v
`timescale 1ns/1ps
`default_nettype none
`include "ttx_port_regs.vh"
// Functional notes
// - Five registers: rx, tx, control A/B, status
// - Select and strobes pick the register
// - Receive register read-only, last valid digit
// - Transmit register write-only, selects tone pair
// - Control A b3 steers next write to B
// - Status read-only, shows live state
// - Control A b0 gates tone_active only, not single or column
// - Control A b1 selects progress or tone mode
// - Progress mode with irq enable: squarewave out
// - Progress mode blocks digit detection
// - Irq low on digit or burst ready
// - No wait states at 16 MHz host
// - Burst mode: burst, pause, then tx empty
// - Control B single tone and column/row pick
// - Test mode mirrors delayed steering on pin in tone mode
// - Status flags; read clears b0 to b2
module ttx_host_port #(
    parameter [31:0] BURST_CYCLES = `TTX_BURST_CYCLES
) (
    input wire ref_clk,
    input wire rst_n,
    input wire chip_select_n,
    input wire register_select_line,
    input wire write_n,
    input wire read_n,
    input wire [3:0] data_in,
    output reg [3:0] data_out,
    output reg data_oe_n,
    input wire digit_valid,
    input wire [3:0] digit_code,
    input wire delayed_steer,
    input wire progress_tone,
    output reg interrupt_or_progress_pin_oe_n,
    output reg tone_active,
    output reg [3:0] tone_code,
    output reg tone_single,
    output reg tone_column
);
    // ==========================================================
    // Bus strobe decode
    reg wr_d;
    reg rd_d;
    reg [3:0] tone_control_a;
    reg [3:0] tone_control_b;
    reg bank_select_bit;
    reg [3:0] status;
    reg dv_d;
    reg [31:0] burst_cnt;
    reg burst_run;
    reg burst_pause;
    reg tx_pending;
    wire [3:0] rx_digit;
    wire wr_now = !chip_select_n && !write_n;
    wire rd_now = !chip_select_n && !read_n;
    // Edge detect so one host cycle is one access; a 16 MHz host strobe
    // spans at least one 25 ns clock, so no wait states are needed
    wire wr_edge = wr_now && !wr_d;
    wire rd_edge = rd_now && !rd_d;
    wire rd_end = !rd_now && rd_d;
    wire wr_tx = wr_edge && register_select_line == `TTX_SEL_DATA;
    wire wr_ctrl = wr_edge && register_select_line == `TTX_SEL_CTRL;
    wire rd_status = rd_end && register_select_line == `TTX_SEL_CTRL;
    wire progress_mode = tone_control_a[`TTX_CTLA_PROGRESS];
    wire burst_mode = !tone_control_b[`TTX_CTLB_BURST_N];
    // Digit accepted only in tone mode
    wire digit_new = digit_valid && !dv_d && !progress_mode;
    wire [31:0] burst_len = progress_mode ? (BURST_CYCLES << 1) : BURST_CYCLES;
    wire burst_done = burst_run && burst_pause && burst_cnt == burst_len - 32'd1;
    wire set_tx_empty = burst_mode && burst_done;
    wire [3:0] next_status;
    reg pin_low;

    // Flag update: hardware set wins over a read clear
    function [3:0] ttx_flags;
        input [3:0] cur;
        input clr;
        input set_rx;
        input set_tx;
        input steer;
        reg rx;
        reg tx;
        begin
            rx = (cur[`TTX_ST_RX_FULL] && !clr) || set_rx;
            tx = (cur[`TTX_ST_TX_EMPTY] && !clr) || set_tx;
            ttx_flags = {steer, rx, tx, rx || tx};
        end
    endfunction

    // ==========================================================
    // Receive digit store
    ttx_digit_reg u_rx (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(digit_new),
        .load_data(digit_code),
        .hold_data(rx_digit)
    );

    // Strobe history
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_d <= 1'b0;
            rd_d <= 1'b0;
            dv_d <= 1'b0;
        end else begin
            wr_d <= wr_now;
            rd_d <= rd_now;
            dv_d <= digit_valid;
        end
    end

    // ==========================================================
    // Control registers sharing one address
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            tone_control_a <= `TTX_CTLA_RESET;
            tone_control_b <= `TTX_CTLB_RESET;
            bank_select_bit <= 1'b0;
        end else if (wr_ctrl) begin
            if (bank_select_bit) begin
                tone_control_b <= data_in;
                bank_select_bit <= 1'b0;
            end else begin
                tone_control_a <= data_in;
                bank_select_bit <= data_in[`TTX_CTLA_BANK_SEL];
            end
        end
    end

    // ==========================================================
    // Status flags; non-burst mode forces tx empty low before the irq
    // summary is formed, so leaving burst mode cannot leave a stale irq
    assign next_status = ttx_flags(burst_mode ? status : (status & 4'hd), rd_status, digit_new,
                                   set_tx_empty, delayed_steer);
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            status <= `TTX_STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // ==========================================================
    // Transmit digit and burst timer
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            tone_code <= 4'h0;
            tx_pending <= 1'b0;
            burst_run <= 1'b0;
            burst_pause <= 1'b0;
            burst_cnt <= 32'h0;
        end else begin
            if (wr_tx) begin
                tone_code <= data_in;
            end
            if (!burst_mode) begin
                burst_run <= 1'b0;
                burst_pause <= 1'b0;
                burst_cnt <= 32'h0;
                tx_pending <= 1'b0;
            end else if (!burst_run) begin
                // A write during a burst waits for the current pause to end
                if (wr_tx || tx_pending) begin
                    burst_run <= 1'b1;
                    tx_pending <= 1'b0;
                    burst_cnt <= 32'h0;
                end
            end else begin
                if (wr_tx) begin
                    tx_pending <= 1'b1;
                end
                if (burst_cnt == burst_len - 32'd1) begin
                    burst_cnt <= 32'h0;
                    burst_pause <= !burst_pause;
                    if (burst_pause) begin
                        burst_run <= 1'b0;
                    end
                end else begin
                    burst_cnt <= burst_cnt + 32'd1;
                end
            end
        end
    end

    // ==========================================================
    // Tone drive: control A b0 gates tone_active only, not single or column
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            tone_active <= 1'b0;
            tone_single <= 1'b0;
            tone_column <= 1'b0;
        end else begin
            tone_active <= tone_control_a[`TTX_CTLA_TONE_OUT] &&
                           (!burst_mode || (burst_run && !burst_pause));
            tone_single <= tone_control_b[`TTX_CTLB_SINGLE];
            tone_column <= tone_control_b[`TTX_CTLB_COLUMN];
        end
    end

    // ==========================================================
    // Pin select: progress wave, test mirror or interrupt
    always @* begin
        if (!tone_control_a[`TTX_CTLA_IRQ_EN] && !tone_control_b[`TTX_CTLB_TEST]) begin
            pin_low = 1'b0;
        end else if (progress_mode) begin
            pin_low = tone_control_a[`TTX_CTLA_IRQ_EN] && !progress_tone;
        end else if (tone_control_b[`TTX_CTLB_TEST]) begin
            pin_low = !status[`TTX_ST_DSTEER];
        end else begin
            pin_low = status[`TTX_ST_IRQ];
        end
    end

    // Open drain: enable low pulls the wire down
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            interrupt_or_progress_pin_oe_n <= 1'b1;
        end else begin
            interrupt_or_progress_pin_oe_n <= !pin_low;
        end
    end

    // ==========================================================
    // Read data: registered, driven only during a read cycle
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            data_out <= 4'h0;
            data_oe_n <= 1'b1;
        end else begin
            data_oe_n <= !rd_now;
            if (rd_edge) begin
                data_out <= (register_select_line == `TTX_SEL_CTRL) ? status : rx_digit;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/ttx_port_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus and output checks at the port pins
module ttx_port_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic register_select_line,
    input wire logic write_n,
    input wire logic read_n,
    input wire logic [3:0] data_out,
    input wire logic data_oe_n,
    input wire logic delayed_steer,
    input wire logic interrupt_or_progress_pin_oe_n,
    input wire logic tone_active,
    input wire logic [3:0] tone_code,
    input wire logic tone_single,
    input wire logic tone_column
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Decoded strobes, as the port sees them at each edge
    wire rd = !chip_select_n && !read_n;
    wire cw = !chip_select_n && !write_n && register_select_line;
    AST_OE_ON: assert property (rd |=> !data_oe_n)
        else $error("read data not driven");
    AST_OE_OFF: assert property (!rd |=> data_oe_n)
        else $error("bus driven outside a read");
    AST_OE_LAG: assert property ($fell(rd) |-> !data_oe_n ##1 data_oe_n)
        else $error("bus release not one cycle after read");
    AST_DOUT_HOLD: assert property ($changed(data_out) |-> $past(rd))
        else $error("read data moved without a read");
    // Control B fields may only move right after a control write
    AST_CTRL_WRITE: assert property ($changed({tone_single, tone_column}) |-> $past(cw) || $past(cw, 2))
        else $error("tone select moved without a control write");
    AST_STATUS_STEER: assert property ($fell(read_n) && rd && register_select_line && $stable(delayed_steer)
        |=> data_out[3] == $past(delayed_steer))
        else $error("status b3 differs from delayed steering");
    AST_RST_TONE: assert property ($rose(rst_n) |-> !tone_active && interrupt_or_progress_pin_oe_n && data_oe_n)
        else $error("tone or pins active after reset");
    AST_RST_SEL: assert property ($rose(rst_n) |-> tone_code == 4'h0 && !tone_single && !tone_column)
        else $error("tone selection not cleared by reset");
endmodule
bind ttx_host_port ttx_port_chk u_ttx_port_chk (.ref_clk, .rst_n, .chip_select_n, .register_select_line, .write_n,
    .read_n, .data_out, .data_oe_n, .delayed_steer, .interrupt_or_progress_pin_oe_n, .tone_active, .tone_code,
    .tone_single, .tone_column);
`default_nettype wire

// file: bench/ttx_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host bus model: fixed-length accesses, no wait states
module ttx_host_model (
    input wire logic ref_clk,
    input wire logic [3:0] data_out,
    input wire logic data_oe_n,
    output logic chip_select_n,
    output logic register_select_line,
    output logic write_n,
    output logic read_n,
    output logic [3:0] data_in
);
    // Idle bus; select is the host's own decode, active low
    initial begin
        {chip_select_n, write_n, read_n, register_select_line, data_in} = 8'hea;
    end
    // Write: held over the taking edge, then a quiet cycle
    task automatic wr(input logic rs, input logic [3:0] d);
        @(negedge ref_clk);
        {chip_select_n, write_n, register_select_line, data_in} = {2'b00, rs, d};
        @(negedge ref_clk);
        {chip_select_n, write_n, data_in} = {2'b11, ~d};
        @(negedge ref_clk);
    endtask
    // Read: data taken two edges in, before the strobe drops
    task automatic rd(input logic rs, output logic [3:0] d);
        @(negedge ref_clk);
        {chip_select_n, read_n, register_select_line} = {2'b00, rs};
        repeat (2) @(negedge ref_clk);
        d = data_oe_n ? ~data_out : data_out; // Undriven bus shows junk, not stale data
        {chip_select_n, read_n} = 2'b11;
        @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

// file: bench/tone_transceiver_host_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
// ==========================================
// Top: port under test, host model, scenarios
module tone_transceiver_host_port_test;
    logic ref_clk = 1'b0, rst_n = 1'b0, dv = 1'b0, ds = 1'b1, pt = 1'b1;
    logic [3:0] dc = 4'h0, d;
    wire cs_n, rsl, wr_n, rd_n, doe_n, pin, ta, ts, tcol;
    wire [3:0] din, dout, tc;
    int fails = 0, comparisons = 0;
    // 40 MHz clock
    initial forever #12.5 ref_clk = ~ref_clk;
    ttx_host_port #(.BURST_CYCLES(32'd20)) u_ttx_host_port (.ref_clk(ref_clk), .rst_n(rst_n), .chip_select_n(cs_n),
        .register_select_line(rsl), .write_n(wr_n), .read_n(rd_n), .data_in(din), .data_out(dout), .data_oe_n(doe_n),
        .digit_valid(dv), .digit_code(dc), .delayed_steer(ds), .progress_tone(pt),
        .interrupt_or_progress_pin_oe_n(pin), .tone_active(ta), .tone_code(tc), .tone_single(ts), .tone_column(tcol));
    ttx_host_model u_ttx_host_model (.ref_clk(ref_clk), .data_out(dout), .data_oe_n(doe_n), .chip_select_n(cs_n),
        .register_select_line(rsl), .write_n(wr_n), .read_n(rd_n), .data_in(din));
    // Short forms of the bus calls
    task automatic cw(input logic [3:0] v); u_ttx_host_model.wr(1'b1, v); endtask
    task automatic w(input int n); repeat (n) @(negedge ref_clk); endtask
    task automatic st(input logic [3:0] e); u_ttx_host_model.rd(1'b1, d); `CHK("status", e, d) endtask
    task automatic pulse(input logic [3:0] c); dc = c; dv = 1'b1; w(3); dv = 1'b0; w(3); endtask
    task final_report;
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Scenarios, inputs moved at falling edges only
    initial begin
        w(4);
        rst_n = 1'b1;
        `CHK("idle outputs", 3'b010, {ta, pin, tc[0]})
        st(4'h8);
        cw(4'h0); cw(4'h0); cw(4'h8); cw(4'h0); st(4'h8);
        $display("test init done");
        cw(4'h1); u_ttx_host_model.wr(1'b0, 4'h7); w(3);
        `CHK("tone on", 5'h17, {ta, tc})
        cw(4'h0); w(3); `CHK("tone off", 1'b0, ta)
        $display("test transmit done");
        cw(4'h9); cw(4'hc); w(2); `CHK("control b", 2'b11, {ts, tcol})
        cw(4'h0); w(3); `CHK("back to a", 3'b011, {ta, ts, tcol})
        $display("test bank select done");
        cw(4'h4); pulse(4'h5); `CHK("digit irq", 1'b0, pin)
        u_ttx_host_model.rd(1'b0, d); `CHK("rx digit", 4'h5, d)
        st(4'hd); st(4'h8); `CHK("irq cleared", 1'b1, pin)
        $display("test receive done");
        cw(4'h6); pt = 1'b0; w(3); `CHK("progress low", 1'b0, pin)
        pt = 1'b1; w(3); `CHK("progress high", 1'b1, pin)
        pulse(4'h3); st(4'h8); u_ttx_host_model.rd(1'b0, d); `CHK("rx held", 4'h5, d)
        $display("test progress done");
        cw(4'h8); cw(4'h3); ds = 1'b0; w(3); `CHK("test pin low", 1'b0, pin)
        st(4'h0); ds = 1'b1; w(3); `CHK("test pin high", 1'b1, pin)
        $display("test steering done");
        cw(4'h8); cw(4'h0); cw(4'h5); u_ttx_host_model.wr(1'b0, 4'h2); w(6);
        `CHK("burst on", 5'h12, {ta, tc})
        w(30); `CHK("pause", 1'b0, ta)
        w(20); `CHK("tx ready irq", 1'b0, pin)
        st(4'hb); st(4'h8);
        $display("test burst done");
        cw(4'h7); u_ttx_host_model.wr(1'b0, 4'h9); w(30);
        `CHK("long burst on", 5'h19, {ta, tc})
        w(30); `CHK("long pause", 1'b0, ta)
        w(30); st(4'hb);
        $display("test long burst done");
        final_report;
    end
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge ref_clk);
        fails++;
        final_report;
    end
endmodule
`default_nettype wire
